// >>> bench/hbmd_dev_model.sv
// Behavioural model of the power stage: serial port, scheme decode, phase states
`timescale 1ns/1ns
module hbmd_dev_model import hbmd_pkg::*; #(
    parameter int READY_NS = 500,
    // Strap level: ground, open, resistor to supply, tie to supply
    parameter logic [1:0] STRAP_LEVEL = 2'h0
) (
    // Power-up and fault stimulus
    input wire logic i_por_n,
    input wire logic i_fault_event,
    // Phase inputs
    input wire logic [2:0] i_high_side_input,
    input wire logic [2:0] i_low_side_input,
    // Serial pins
    input wire logic i_sclk,
    input wire logic i_sdi,
    input wire logic i_serial_select_n,
    output logic o_sdo_low,
    output logic o_fault_indicator_n,
    // Observation
    output hbmd_mode_e o_mode,
    output logic [2:0] o_hs_on,
    output logic [2:0] o_ls_on,
    output int o_viol
);
    time t_por, t_sel_rise, t_sck_rise, t_sck_fall;
    logic [15:0] rx_ff, tx_ff;
    int cnt_ff, idx_ff;
    logic fault_ff;

    // ------------------------------------------------------------
    // Phase decode
    // ------------------------------------------------------------
    // Limit variants decode exactly like their base scheme
    assign o_hs_on = o_mode[1] ? (i_high_side_input & i_low_side_input) :
                     (i_high_side_input & ~i_low_side_input);
    assign o_ls_on = i_low_side_input & ~i_high_side_input;
    assign o_fault_indicator_n = ~i_fault_event;
    // Open drain: released means the pull-up wins
    assign o_sdo_low = !i_serial_select_n && !tx_ff[idx_ff];

    // ------------------------------------------------------------
    // Serial port and host timing watch
    // ------------------------------------------------------------
    initial begin
        o_viol = 0;
        o_mode = hbmd_mode_e'(STRAP_LEVEL);
        fault_ff = 1'b0;
        t_sel_rise = 0;
        idx_ff = 15;
        tx_ff = 16'hFFFF;
    end

    always @(negedge i_por_n or posedge i_por_n) begin
        if (!i_por_n) begin
            // Strap levels pick the four schemes in code order
            o_mode = hbmd_mode_e'(STRAP_LEVEL);
            fault_ff = 1'b0;
        end else begin
            t_por = $time;
        end
    end

    always @(posedge i_fault_event) fault_ff = 1'b1;

    always @(negedge i_serial_select_n) begin
        if ($time - t_por < READY_NS) o_viol++;
        if ($time - t_sel_rise < SEL_HIGH_NS) o_viol++;
        cnt_ff = 0;
        idx_ff = 15;
        t_sck_fall = $time;
        tx_ff = {7'h00, fault_ff, 8'h00};
    end

    always @(posedge i_sclk) begin
        if (!i_serial_select_n) begin
            if ($time - t_sck_fall < SCLK_LOW_NS) o_viol++;
            if (cnt_ff > 0 && $time - t_sck_rise < SCLK_PERIOD_NS) o_viol++;
            idx_ff = 15 - cnt_ff;
            t_sck_rise = $time;
        end
    end

    always @(negedge i_sclk) begin
        if (!i_serial_select_n) begin
            if ($time - t_sck_rise < SCLK_HIGH_NS) o_viol++;
            rx_ff = {rx_ff[14:0], i_sdi};
            cnt_ff++;
            t_sck_fall = $time;
            // Address is known after seven bits, data byte leaves later
            if (cnt_ff == 7 && rx_ff[5:0] == MODE_REG_ADDR) tx_ff[1:0] = o_mode;
        end
    end

    always @(posedge i_serial_select_n) begin
        if (i_por_n === 1'b1) begin
            if ($time - t_sck_fall < SEL_HOLD_NS || cnt_ff != 16) o_viol++;
            if (cnt_ff == 16 && rx_ff[15] == FRAME_WRITE && rx_ff[14:9] == MODE_REG_ADDR) begin
                if ((i_high_side_input | i_low_side_input) != 3'h0) o_viol++;
                o_mode = hbmd_mode_e'(rx_ff[PWM_MODE_LSB +: 2]);
            end
            t_sel_rise = $time;
        end
    end
endmodule : hbmd_dev_model

// >>> bench/hbmd_host_tb.sv
// Self-checking bench for the half-bridge host controller
`timescale 1ns/1ns
module hbmd_host_tb import hbmd_pkg::*;;
    localparam int READY_SIM = 50;
    logic i_sys_clk = 1'b0;
    logic i_arst_n = 1'b0;
    hbmd_drive_s i_drive = hbmd_drive_s'(6'h3F);
    logic i_mode_valid = 1'b0;
    hbmd_mode_e i_mode = MODE_SIX;
    logic i_xfer_valid = 1'b0;
    logic [FRAME_W-1:0] i_xfer_word = 16'h0000;
    logic fault_event = 1'b0;
    logic o_link_ready, o_busy, o_xfer_done, o_fault_seen;
    logic [FRAME_W-1:0] o_xfer_rdata;
    hbmd_mode_e o_mode_active, dev_mode;
    logic [2:0] o_high_side_input, o_low_side_input, hs_on, ls_on;
    logic o_sclk, o_sdi, o_serial_select_n, sdo_low, fault_n;
    wire logic i_sdo;
    int dev_viol;
    int bad_count = 0;
    int tests_run = 0;

    // Pull-up on the open-drain data line
    assign i_sdo = sdo_low ? 1'b0 : 1'b1;
    always #5 i_sys_clk = ~i_sys_clk;

    hbmd_host #(.READY_WAIT_CYC(READY_SIM)) i_dut (
        .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_drive(i_drive),
        .i_mode_valid(i_mode_valid), .i_mode(i_mode), .i_xfer_valid(i_xfer_valid),
        .i_xfer_word(i_xfer_word), .o_link_ready(o_link_ready), .o_busy(o_busy),
        .o_xfer_done(o_xfer_done), .o_xfer_rdata(o_xfer_rdata),
        .o_mode_active(o_mode_active), .o_fault_seen(o_fault_seen),
        .o_high_side_input(o_high_side_input), .o_low_side_input(o_low_side_input),
        .o_sclk(o_sclk), .o_sdi(o_sdi), .o_serial_select_n(o_serial_select_n),
        .i_sdo(i_sdo), .i_fault_indicator_n(fault_n));

    hbmd_dev_model #(.READY_NS(READY_SIM * CLK_PERIOD_NS)) i_dev (
        .i_por_n(i_arst_n), .i_fault_event(fault_event),
        .i_high_side_input(o_high_side_input), .i_low_side_input(o_low_side_input),
        .i_sclk(o_sclk), .i_sdi(o_sdi), .i_serial_select_n(o_serial_select_n),
        .o_sdo_low(sdo_low), .o_fault_indicator_n(fault_n), .o_mode(dev_mode),
        .o_hs_on(hs_on), .o_ls_on(ls_on), .o_viol(dev_viol));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic give_verdict();
        $display("checks run %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Drive is requested all along, so only the hold-off keeps pins low
    task automatic t_ready();
        int n;
        logic quiet;
        n = 0;
        quiet = 1'b1;
        while (o_link_ready !== 1'b1 && n < 400) begin
            @(posedge i_sys_clk);
            #1;
            n++;
            if (o_link_ready !== 1'b1 && {o_high_side_input, o_low_side_input} !== 6'h00) begin
                quiet = 1'b0;
            end
        end
        chk("ready wait cycles", 16'(READY_SIM), 16'(n));
        chk("pins quiet before ready", 16'h0001, {15'h0000, quiet});
        chk("strap scheme", {14'h0000, MODE_SIX}, {14'h0000, dev_mode});
    endtask : t_ready

    task automatic t_drive(input hbmd_mode_e m);
        logic [5:0] pats [4] = '{6'b101_011, 6'b010_100, 6'b000_000, 6'b111_111};
        logic [2:0] h, l;
        foreach (pats[k]) begin
            @(posedge i_sys_clk);
            i_drive <= hbmd_drive_s'(pats[k]);
            @(posedge i_sys_clk);
            #1;
            h = pats[k][5:3];
            l = pats[k][2:0];
            chk("pin drive", {10'h000, pats[k]}, {10'h000, o_high_side_input, o_low_side_input});
            chk("high switch", {13'h0000, m[1] ? (h & l) : (h & ~l)}, {13'h0000, hs_on});
            chk("low switch", {13'h0000, l & ~h}, {13'h0000, ls_on});
        end
    endtask : t_drive

    task automatic t_mode(input hbmd_mode_e m);
        int n;
        logic quiet;
        n = 0;
        quiet = 1'b1;
        @(posedge i_sys_clk);
        i_drive <= hbmd_drive_s'(6'b110_011);
        i_mode <= m;
        i_mode_valid <= 1'b1;
        while (o_busy !== 1'b1 && n < 100) begin
            @(posedge i_sys_clk);
            n++;
        end
        i_mode_valid <= 1'b0;
        while (o_busy === 1'b1 && n < 600) begin
            if ({o_high_side_input, o_low_side_input} !== 6'h00) quiet = 1'b0;
            @(posedge i_sys_clk);
            n++;
        end
        #1;
        chk("mode change finished", 16'h0001, 16'(n < 600));
        chk("pins low during change", 16'h0001, {15'h0000, quiet});
        chk("mode written", {14'h0000, m}, {14'h0000, o_mode_active});
        chk("device scheme", {14'h0000, m}, {14'h0000, dev_mode});
    endtask : t_mode

    // Two reads back to back; the second waits out the select gap
    task automatic t_frames(input hbmd_mode_e m);
        int n;
        chk("fault idle", 16'h0000, {15'h0000, o_fault_seen});
        @(posedge i_sys_clk);
        fault_event <= 1'b1;
        i_xfer_word <= 16'h8C00;
        repeat (2) begin
            i_xfer_valid <= 1'b1;
            n = 0;
            while (o_serial_select_n !== 1'b0 && n < 200) begin
                @(posedge i_sys_clk);
                n++;
            end
            i_xfer_valid <= 1'b0;
            while (o_xfer_done !== 1'b1 && n < 600) begin
                @(posedge i_sys_clk);
                n++;
            end
            chk("frame finished", 16'h0001, 16'(n < 600));
            chk("read word", {7'h00, 1'b1, 6'h00, m}, o_xfer_rdata);
        end
        #1;
        chk("fault seen", 16'h0001, {15'h0000, o_fault_seen});
        chk("device timing faults", 16'h0000, 16'(dev_viol));
        @(posedge i_sys_clk);
        fault_event <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        #1;
        chk("fault cleared", 16'h0000, {15'h0000, o_fault_seen});
    endtask : t_frames

    // ------------------------------------------------------------
    // Sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge i_sys_clk);
        i_arst_n <= 1'b1;
        t_ready();
        t_drive(MODE_SIX);
        for (int k = 0; k < 4; k++) begin
            t_mode(hbmd_mode_e'(k[1:0]));
            t_drive(hbmd_mode_e'(k[1:0]));
        end
        t_frames(MODE_THREE_LIMIT);
        give_verdict();
    end

    // Whole run is about 1200 cycles
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        bad_count++;
        give_verdict();
    end
endmodule : hbmd_host_tb

// >>> logic/hbmd_host.sv
// Host controller for a three-phase half-bridge stage: PWM inputs, mode writes, serial port
`timescale 1ns/1ns

// Function
// - Host forces every phase input low before and while changing the mode.
// - Host waits the serial readiness time after reset before any frame.
// - Host keeps select high at least the minimum time between frames.
// - Host serial clock meets minimum period and minimum high and low times.
module hbmd_host import hbmd_pkg::*; #(
    parameter int READY_WAIT_CYC = READY_CYC
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // Requested phase drive from the commutation logic
    input wire hbmd_drive_s i_drive,
    // Mode change request
    input wire logic i_mode_valid,
    input wire hbmd_mode_e i_mode,
    // Raw serial frame request
    input wire logic i_xfer_valid,
    input wire logic [FRAME_W-1:0] i_xfer_word,
    // Status toward the user
    output logic o_link_ready,
    output logic o_busy,
    output logic o_xfer_done,
    output logic [FRAME_W-1:0] o_xfer_rdata,
    output hbmd_mode_e o_mode_active,
    output logic o_fault_seen,
    // Device pins
    output logic [2:0] o_high_side_input,
    output logic [2:0] o_low_side_input,
    output logic o_sclk,
    output logic o_sdi,
    output logic o_serial_select_n,
    input wire logic i_sdo,
    input wire logic i_fault_indicator_n
);

    // ------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_WAIT_READY = 3'b000,
        ST_IDLE = 3'b001,
        ST_QUIESCE = 3'b010,
        ST_MODE_XFER = 3'b011,
        ST_USER_XFER = 3'b100
    } hbmd_state_e;

    localparam int RDY_W = $clog2(READY_WAIT_CYC + 1);

    hbmd_state_e state_ff;
    hbmd_state_e nxt_state;
    logic [RDY_W-1:0] rdy_cnt_ff;
    logic [CNT_W-1:0] q_cnt_ff;
    logic ready_ff;
    logic start_ff;
    logic [FRAME_W-1:0] frame_ff;
    hbmd_mode_e mode_req_ff;
    hbmd_mode_e mode_act_ff;
    hbmd_drive_s drive_ff;
    hbmd_drive_s nxt_drive;
    logic fault_ff;
    logic done_ff;
    logic [FRAME_W-1:0] rdata_ff;
    logic busy_ff;

    // Engine wires
    logic sh_busy;
    logic sh_done;
    logic [FRAME_W-1:0] sh_rx;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire rdy_hit = (rdy_cnt_ff == RDY_W'(READY_WAIT_CYC - 1));
    wire q_zero = (q_cnt_ff == '0);
    wire can_issue = ready_ff && !sh_busy && !start_ff;
    wire take_mode = (state_ff == ST_IDLE) && i_mode_valid;
    wire take_xfer = (state_ff == ST_IDLE) && !i_mode_valid && i_xfer_valid && can_issue;
    wire quiet_done = (state_ff == ST_QUIESCE) && q_zero && can_issue;
    // Drive held off while the scheme may be in flux
    wire hold_off = (state_ff == ST_WAIT_READY) || (state_ff == ST_QUIESCE) ||
                    (state_ff == ST_MODE_XFER) || take_mode;
    wire [7:0] mode_data = 8'({6'h00, mode_req_ff} << PWM_MODE_LSB);
    wire [FRAME_W-1:0] mode_frame = {FRAME_WRITE, MODE_REG_ADDR, 1'b0, mode_data};

    assign nxt_drive = hold_off ? DRIVE_OFF : i_drive;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_WAIT_READY: begin
                if (rdy_hit) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (take_mode) begin
                    nxt_state = ST_QUIESCE;
                end else if (take_xfer) begin
                    nxt_state = ST_USER_XFER;
                end
            end
            ST_QUIESCE: begin
                if (quiet_done) begin
                    nxt_state = ST_MODE_XFER;
                end
            end
            ST_MODE_XFER, ST_USER_XFER: begin
                if (sh_done) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_WAIT_READY;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Sequencing registers
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_ff <= ST_WAIT_READY;
            rdy_cnt_ff <= '0;
            ready_ff <= 1'b0;
            busy_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            // Same timing as a state decode, but the pin leaves a flop
            busy_ff <= (nxt_state != ST_IDLE);
            if (!ready_ff) begin
                rdy_cnt_ff <= rdy_cnt_ff + 1'b1;
                ready_ff <= rdy_hit;
            end
        end
    end

    // Quiet time counts from the cycle the inputs were first forced low
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            q_cnt_ff <= '0;
            mode_req_ff <= MODE_SIX;
        end else if (take_mode) begin
            q_cnt_ff <= CNT_W'(QUIESCE_CYC - 1);
            mode_req_ff <= i_mode;
        end else if (!q_zero) begin
            q_cnt_ff <= q_cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            start_ff <= 1'b0;
            frame_ff <= '0;
        end else begin
            start_ff <= quiet_done || take_xfer;
            frame_ff <= quiet_done ? mode_frame : i_xfer_word;
        end
    end

    // ------------------------------------------------------------
    // Results and pins
    // ------------------------------------------------------------
    // Active mode only updates once the write frame has closed
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mode_act_ff <= MODE_SIX;
            done_ff <= 1'b0;
            rdata_ff <= '0;
            drive_ff <= DRIVE_OFF;
            fault_ff <= 1'b0;
        end else begin
            if (state_ff == ST_MODE_XFER && sh_done) begin
                mode_act_ff <= mode_req_ff;
            end
            done_ff <= (state_ff == ST_USER_XFER) && sh_done;
            if ((state_ff == ST_USER_XFER) && sh_done) begin
                rdata_ff <= sh_rx;
            end
            drive_ff <= nxt_drive;
            fault_ff <= !i_fault_indicator_n;
        end
    end

    assign o_link_ready = ready_ff;
    assign o_busy = busy_ff;
    assign o_xfer_done = done_ff;
    assign o_xfer_rdata = rdata_ff;
    assign o_mode_active = mode_act_ff;
    assign o_fault_seen = fault_ff;
    assign o_high_side_input = drive_ff.high_side_input;
    assign o_low_side_input = drive_ff.low_side_input;

    hbmd_spi_shift #(
        .WORD_W(FRAME_W)
    ) u_shift (
        .i_sys_clk(i_sys_clk),
        .i_arst_n(i_arst_n),
        .i_start(start_ff),
        .i_tx_word(frame_ff),
        .o_busy(sh_busy),
        .o_done(sh_done),
        .o_rx_word(sh_rx),
        .o_sclk(o_sclk),
        .o_sdi(o_sdi),
        .o_serial_select_n(o_serial_select_n),
        .i_sdo(i_sdo)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [RDY_W-1:0] since_rst_ff;
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            since_rst_ff <= '0;
        end else if (since_rst_ff != RDY_W'(READY_WAIT_CYC)) begin
            since_rst_ff <= since_rst_ff + 1'b1;
        end
    end

    sequence s_quiet;
        (drive_ff == DRIVE_OFF) [*2];
    endsequence

    ready_wait_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        !o_serial_select_n |-> since_rst_ff == RDY_W'(READY_WAIT_CYC))
        else $error("serial frame started before readiness time");
    ready_flag_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        $rose(ready_ff) |-> $past(rdy_cnt_ff) == RDY_W'(READY_WAIT_CYC - 1))
        else $error("ready flag raised at the wrong count");
    mode_quiet_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (state_ff == ST_MODE_XFER) && start_ff |-> $past(drive_ff == DRIVE_OFF, 2))
        else $error("mode write began with phase inputs active");
    mode_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        $rose(state_ff == ST_QUIESCE) |-> s_quiet)
        else $error("phase inputs not forced low for mode change");
    xfer_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (state_ff == ST_MODE_XFER) |-> drive_ff == DRIVE_OFF)
        else $error("phase inputs active during mode write");

endmodule : hbmd_host

// >>> logic/hbmd_pkg.sv
// Shared constants, types and timing figures for the half-bridge mode host
package hbmd_pkg;

    // ------------------------------------------------------------
    // Clock and serial-port timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int READY_TIME_MS = 1;
    localparam int SEL_HIGH_NS = 300;
    localparam int SEL_SETUP_NS = 25;
    localparam int SEL_HOLD_NS = 25;
    localparam int SCLK_PERIOD_NS = 100;
    localparam int SCLK_HIGH_NS = 50;
    localparam int SCLK_LOW_NS = 50;

    // Least times round up, never below one cycle
    function automatic int cyc_ceil(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_ceil

    localparam int READY_CYC = cyc_ceil(READY_TIME_MS * 1000000);
    localparam int SEL_HIGH_CYC = cyc_ceil(SEL_HIGH_NS);
    localparam int SCLK_HIGH_CYC = cyc_ceil(SCLK_HIGH_NS);
    localparam int SCLK_LOW_CYC = cyc_ceil(SCLK_LOW_NS);
    // Low phase already covers the setup need; taller of the two wins
    localparam int SEL_LEAD_CYC = (cyc_ceil(SEL_SETUP_NS) > SCLK_LOW_CYC) ?
                                  cyc_ceil(SEL_SETUP_NS) : SCLK_LOW_CYC;
    localparam int SEL_TAIL_CYC = cyc_ceil(SEL_HOLD_NS);
    localparam int QUIESCE_CYC = 2;
    localparam int CNT_W = 8;

    // ------------------------------------------------------------
    // Serial frame layout and mode field placement
    // ------------------------------------------------------------
    localparam int FRAME_W = 16;
    localparam logic FRAME_WRITE = 1'b0;
    localparam logic [5:0] MODE_REG_ADDR = 6'h06;
    localparam int PWM_MODE_LSB = 0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_SIX = 2'b00,
        MODE_SIX_LIMIT = 2'b01,
        MODE_THREE = 2'b10,
        MODE_THREE_LIMIT = 2'b11
    } hbmd_mode_e;

    typedef struct packed {
        logic [2:0] high_side_input;
        logic [2:0] low_side_input;
    } hbmd_drive_s;

    localparam hbmd_drive_s DRIVE_OFF = '{high_side_input: 3'h0, low_side_input: 3'h0};

endpackage : hbmd_pkg

// >>> logic/hbmd_spi_shift.sv
// Serial frame engine: select, clock pacing, shift and inter-frame gap
`timescale 1ns/1ns
module hbmd_spi_shift import hbmd_pkg::*; #(
    parameter int WORD_W = FRAME_W
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // Frame request and result
    input wire logic i_start,
    input wire logic [WORD_W-1:0] i_tx_word,
    output logic o_busy,
    output logic o_done,
    output logic [WORD_W-1:0] o_rx_word,
    // Serial pins
    output logic o_sclk,
    output logic o_sdi,
    output logic o_serial_select_n,
    input wire logic i_sdo
);

    typedef enum logic [2:0] {
        SH_IDLE = 3'b000,
        SH_LEAD = 3'b001,
        SH_HIGH = 3'b010,
        SH_LOW = 3'b011,
        SH_TAIL = 3'b100,
        SH_GAP = 3'b101
    } hbmd_sh_e;

    hbmd_sh_e state_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [$clog2(WORD_W)-1:0] bits_ff;
    logic [WORD_W-1:0] tx_ff;
    logic [WORD_W-1:0] rx_ff;
    logic sclk_ff;
    logic sdi_ff;
    logic sel_n_ff;
    logic done_ff;

    wire cnt_zero = (cnt_ff == '0);
    wire last_bit = (bits_ff == '0);

    assign o_busy = (state_ff != SH_IDLE);
    assign o_done = done_ff;
    assign o_rx_word = rx_ff;
    assign o_sclk = sclk_ff;
    assign o_sdi = sdi_ff;
    assign o_serial_select_n = sel_n_ff;

    // ------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------
    // Data leaves on the rising edge, both sides sample on the falling one
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_ff <= SH_IDLE;
            cnt_ff <= '0;
            bits_ff <= '0;
            tx_ff <= '0;
            rx_ff <= '0;
            sclk_ff <= 1'b0;
            sdi_ff <= 1'b0;
            sel_n_ff <= 1'b1;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (state_ff != SH_IDLE && !cnt_zero) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
            unique case (state_ff)
                SH_IDLE: begin
                    if (i_start) begin
                        sel_n_ff <= 1'b0;
                        tx_ff <= i_tx_word;
                        sdi_ff <= i_tx_word[WORD_W-1];
                        cnt_ff <= CNT_W'(SEL_LEAD_CYC - 1);
                        state_ff <= SH_LEAD;
                    end
                end
                SH_LEAD: begin
                    if (cnt_zero) begin
                        sclk_ff <= 1'b1;
                        bits_ff <= ($clog2(WORD_W))'(WORD_W - 1);
                        cnt_ff <= CNT_W'(SCLK_HIGH_CYC - 1);
                        state_ff <= SH_HIGH;
                    end
                end
                SH_HIGH: begin
                    if (cnt_zero) begin
                        sclk_ff <= 1'b0;
                        rx_ff <= {rx_ff[WORD_W-2:0], i_sdo};
                        tx_ff <= {tx_ff[WORD_W-2:0], 1'b0};
                        bits_ff <= bits_ff - 1'b1;
                        cnt_ff <= last_bit ? CNT_W'(SEL_TAIL_CYC - 1) : CNT_W'(SCLK_LOW_CYC - 1);
                        state_ff <= last_bit ? SH_TAIL : SH_LOW;
                    end
                end
                SH_LOW: begin
                    if (cnt_zero) begin
                        sclk_ff <= 1'b1;
                        sdi_ff <= tx_ff[WORD_W-1];
                        cnt_ff <= CNT_W'(SCLK_HIGH_CYC - 1);
                        state_ff <= SH_HIGH;
                    end
                end
                SH_TAIL: begin
                    if (cnt_zero) begin
                        sel_n_ff <= 1'b1;
                        done_ff <= 1'b1;
                        cnt_ff <= CNT_W'(SEL_HIGH_CYC - 1);
                        state_ff <= SH_GAP;
                    end
                end
                SH_GAP: begin
                    if (cnt_zero) begin
                        state_ff <= SH_IDLE;
                    end
                end
                default: begin
                    state_ff <= SH_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [CNT_W-1:0] hi_run_ff;
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            hi_run_ff <= '1;
        end else if (!sel_n_ff) begin
            hi_run_ff <= '0;
        end else if (hi_run_ff != '1) begin
            hi_run_ff <= hi_run_ff + 1'b1;
        end
    end

    sequence s_high_phase;
        sclk_ff [*5];
    endsequence
    sequence s_low_phase;
        !sclk_ff [*5];
    endsequence

    sel_gap_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        $fell(sel_n_ff) |-> $past(hi_run_ff) >= CNT_W'(SEL_HIGH_CYC - 1))
        else $error("select high time too short between frames");
    sclk_high_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        $rose(sclk_ff) |-> s_high_phase)
        else $error("serial clock high phase too short");
    sclk_low_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        $fell(sclk_ff) && !sel_n_ff |-> s_low_phase)
        else $error("serial clock low phase too short");
    sclk_idle_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        sel_n_ff |-> !sclk_ff)
        else $error("serial clock moved while deselected");

endmodule : hbmd_spi_shift
